// file: verilog/serb_result_word.sv
// serial encoder result word b: apb slave, word assembly and data ready
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "serb_consts.svh"

module serb_result_word (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // apb slave
    input wire serb_pkg::serb_apb_req_t apb_req,
    output serb_pkg::serb_apb_rsp_t apb_rsp,
    // receiver side
    input wire logic rx_start,
    input wire logic rx_done,
    input wire serb_pkg::serb_rx_t rx_data,
    output logic [15:0] cmd_code,
    output serb_pkg::serb_proto_t proto_sel
);
    import serb_pkg::*;

    logic [31:0] word_q;
    logic [31:0] word_d;
    logic ready_q;
    logic [15:0] cmd_q;
    serb_proto_t proto_q;
    logic [31:0] rdata_q;
    logic slverr_q;
    logic acc;
    logic hit_ctrl;
    logic hit_res;

    function automatic logic is_two_frame(input logic [15:0] cmd);
        logic [5:0] c;
        c = cmd[5:0];
        return (c == `SERB_CMD_ADD_A) || (c == `SERB_CMD_ADD_B);
    endfunction : is_two_frame

    function automatic logic [31:0] build_word(input serb_proto_t p, input logic [15:0] cmd,
                                               input serb_rx_t r);
        logic [31:0] w;
        w = `SERB_RESULT_RESET;
        w[`SERB_B_TIMEOUT] = r.timeout;
        unique case (p)
            SERB_PROTO_CMD: begin
                w[`SERB_B_CRC_P] = r.crc_pos;
                if (is_two_frame(cmd)) begin
                    w[`SERB_B_CRC_ADD] = r.crc_add;
                    w[`SERB_B_ERR1] = r.err1;
                    w[`SERB_B_ERR2] = r.err2;
                    w[`SERB_B_WARN] = r.encoder_warning_flag;
                    w[`SERB_B_REFM] = r.reference_mark_flag;
                    w[`SERB_B_BUSY] = r.busy;
                    w[`SERB_B_MRS_HI:`SERB_B_MRS_LO] = r.memory_range_select_code;
                    w[`SERB_B_ADD_HI:0] = r.add_data;
                end else begin
                    // other codes get the single-frame layout too
                    w[`SERB_B_ERR_SINGLE] = r.err1;
                    w[`SERB_B_POS8_HI:0] = r.pos_upper8;
                end
            end
            SERB_PROTO_MOTOR: begin
                w[`SERB_B_CRC_P] = r.crc_pos;
                if (cmd == `SERB_MCMD_ERRCODE) begin
                    w[`SERB_B_MTE_HI:`SERB_B_MTE_LO] = r.mte_error_code;
                end else begin
                    w[`SERB_B_MTE_HI:`SERB_B_MTE_LO] = r.mte_status;
                end
                w[`SERB_B_MT7_HI:0] = r.multiturn_upper7;
            end
            default: begin
                // status-only or unused protocol code: only the timeout flag is meaningful
                w[`SERB_B_TIMEOUT] = r.timeout;
            end
        endcase
        return w;
    endfunction : build_word

    assign word_d = build_word(proto_q, cmd_q, rx_data);
    assign acc = apb_req.psel && apb_req.penable;
    assign hit_ctrl = apb_req.paddr == `SERB_OFS_CTRL;
    assign hit_res = apb_req.paddr == `SERB_OFS_RESULT_B;

    // result word latches only on reception done
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            word_q <= `SERB_RESULT_RESET;
        end else if (rx_done) begin
            word_q <= word_d;
        end
    end

    // done wins over a start in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ready_q <= 1'b0;
        end else if (rx_done) begin
            ready_q <= 1'b1;
        end else if (rx_start) begin
            ready_q <= 1'b0;
        end
    end

    // control: writes to the result word fall through untouched
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= 16'(`SERB_CTRL_RESET >> `SERB_CTRL_CMD_LO);
            proto_q <= SERB_PROTO_STATUS;
        end else if (acc && apb_req.pwrite && hit_ctrl) begin
            cmd_q <= apb_req.pwdata[`SERB_CTRL_CMD_HI:`SERB_CTRL_CMD_LO];
            proto_q <= serb_proto_t'(apb_req.pwdata[`SERB_CTRL_PROTO_HI:`SERB_CTRL_PROTO_LO]);
        end
    end

    // read data registered in the setup cycle so the access cycle answers at once
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (apb_req.psel && !apb_req.penable) begin
            rdata_q <= 32'h0000_0000;
            slverr_q <= !(hit_ctrl || hit_res);
            if (!apb_req.pwrite && hit_res) begin
                rdata_q <= word_q;
            end else if (!apb_req.pwrite && hit_ctrl) begin
                rdata_q <= {cmd_q, 5'h00, ready_q, 8'h00, 2'(proto_q)};
            end
        end
    end

    assign apb_rsp = {1'b1, acc && slverr_q, rdata_q};
    assign cmd_code = cmd_q;
    assign proto_sel = proto_q;

    // checks
    property p_timeout;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done |=> word_q[`SERB_B_TIMEOUT] == $past(rx_data.timeout);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag not captured");

    property p_crc_pos;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && (proto_q == SERB_PROTO_CMD || proto_q == SERB_PROTO_MOTOR)
            |=> word_q[`SERB_B_CRC_P] == $past(rx_data.crc_pos);
    endproperty
    a_crc_pos: assert property (p_crc_pos) else $error("position crc flag wrong");

    property p_single_err;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_POS_A
            |=> word_q[`SERB_B_ERR_SINGLE] == $past(rx_data.err1)
                && word_q[28:8] == 21'h0;
    endproperty
    a_single_err: assert property (p_single_err) else $error("single-frame error bit wrong");

    property p_single_pos;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_POS_B
            |=> word_q[7:0] == $past(rx_data.pos_upper8);
    endproperty
    a_single_pos: assert property (p_single_pos) else $error("position upper bits wrong");

    property p_two_crc;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && is_two_frame(cmd_q)
            |=> word_q[30:29] == {$past(rx_data.crc_pos), $past(rx_data.crc_add)}
                && !word_q[28];
    endproperty
    a_two_crc: assert property (p_two_crc) else $error("two-frame crc flags wrong");

    property p_two_status;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_ADD_A
            |=> word_q[27:21] == {$past(rx_data.err1), $past(rx_data.err2), 2'b00,
                $past(rx_data.encoder_warning_flag), $past(rx_data.reference_mark_flag),
                $past(rx_data.busy)};
    endproperty
    a_two_status: assert property (p_two_status) else $error("two-frame status bits wrong");

    property p_two_data;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_ADD_B
            |=> word_q[20:0] == {$past(rx_data.memory_range_select_code), $past(rx_data.add_data)};
    endproperty
    a_two_data: assert property (p_two_data) else $error("range code or data wrong");

    property p_motor;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_MOTOR
            |=> word_q[23:8] == ($past(cmd_q) == `SERB_MCMD_ERRCODE ? $past(rx_data.mte_error_code)
                : $past(rx_data.mte_status))
                && word_q[7:0] == {1'b0, $past(rx_data.multiturn_upper7)};
    endproperty
    a_motor: assert property (p_motor) else $error("motor encoder fields wrong");

    property p_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        !rx_done |=> $stable(word_q);
    endproperty
    a_hold: assert property (p_hold) else $error("result word changed without reception");

    property p_ready;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_start && !rx_done ##1 !rx_done [*2] |-> !ready_q;
    endproperty
    a_ready: assert property (p_ready) else $error("ready set during reception");

    property p_read_only;
        @(posedge sys_clk) disable iff (!reset_n)
        acc && apb_req.pwrite && hit_res && !rx_done |-> !apb_rsp.pslverr ##1 $stable(word_q);
    endproperty
    a_read_only: assert property (p_read_only) else $error("write altered result word");

    property p_ready_set;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done |=> ready_q;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set on done");

    property p_ready_clear;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_start && !rx_done |=> !ready_q;
    endproperty
    a_ready_clear: assert property (p_ready_clear) else $error("ready not cleared on start");

    property p_ready_hold;
        @(posedge sys_clk) disable iff (!reset_n)
        !rx_start && !rx_done |=> $stable(ready_q);
    endproperty
    a_ready_hold: assert property (p_ready_hold) else $error("ready changed without event");

    property p_unmapped;
        @(posedge sys_clk) disable iff (!reset_n)
        acc && !(hit_ctrl || hit_res) |-> apb_rsp.pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");

    property p_result_no_err;
        @(posedge sys_clk) disable iff (!reset_n)
        acc && hit_res |-> !apb_rsp.pslverr;
    endproperty
    a_result_no_err: assert property (p_result_no_err) else $error("result access errored");

    property p_result_read;
        @(posedge sys_clk) disable iff (!reset_n)
        acc && !apb_req.pwrite && hit_res && !$past(apb_req.penable)
            |-> apb_rsp.prdata == $past(word_q);
    endproperty
    a_result_read: assert property (p_result_read) else $error("result read data wrong");

    property p_ctrl_read;
        @(posedge sys_clk) disable iff (!reset_n)
        acc && !apb_req.pwrite && hit_ctrl && !$past(apb_req.penable)
            |-> apb_rsp.prdata[`SERB_CTRL_READY_BIT] == $past(ready_q)
                && apb_rsp.prdata[15:11] == 5'h00 && apb_rsp.prdata[9:2] == 8'h00;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("data ready bit read wrong");

    property p_status_proto;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_STATUS |=> word_q[30:0] == 31'h0;
    endproperty
    a_status_proto: assert property (p_status_proto) else $error("status-only word not clear");

    property p_single_layout;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && !is_two_frame(cmd_q)
            |=> word_q[30:0] == {$past(rx_data.crc_pos), $past(rx_data.err1), 21'h0,
                $past(rx_data.pos_upper8)};
    endproperty
    a_single_layout: assert property (p_single_layout) else $error("single-frame word wrong");

    property p_two_reserved;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && is_two_frame(cmd_q)
            |=> !word_q[28] && word_q[25:24] == 2'b00;
    endproperty
    a_two_reserved: assert property (p_two_reserved) else $error("two-frame reserved bits set");

    property p_two_data_a;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_ADD_A
            |=> word_q[20:0] == {$past(rx_data.memory_range_select_code), $past(rx_data.add_data)};
    endproperty
    a_two_data_a: assert property (p_two_data_a) else $error("range code echo wrong");

    property p_two_status_b;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_CMD && cmd_q[5:0] == `SERB_CMD_ADD_B
            |=> word_q[27:21] == {$past(rx_data.err1), $past(rx_data.err2), 2'b00,
                $past(rx_data.encoder_warning_flag), $past(rx_data.reference_mark_flag),
                $past(rx_data.busy)};
    endproperty
    a_two_status_b: assert property (p_two_status_b) else $error("two-frame error bits wrong");

    property p_motor_reserved;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_MOTOR
            |=> word_q[30:24] == {$past(rx_data.crc_pos), 6'h00} && !word_q[7];
    endproperty
    a_motor_reserved: assert property (p_motor_reserved) else $error("motor reserved bits set");

    property p_motor_status;
        @(posedge sys_clk) disable iff (!reset_n)
        rx_done && proto_q == SERB_PROTO_MOTOR && cmd_q != `SERB_MCMD_ERRCODE
            |=> word_q[23:8] == $past(rx_data.mte_status);
    endproperty
    a_motor_status: assert property (p_motor_status) else $error("motor status summary wrong");

endmodule : serb_result_word
`default_nettype wire

// file: verilog/serb_consts.svh
// constants for the serial encoder result word block
//
// Behaviour
// - bit 31 shows reception timeout, every protocol
// - single-frame: bit 30 shows frame CRC error
// - codes 000111, 101010: encoder error bit in 29
// - single-frame: position upper eight bits in 7:0
// - codes 111000, 101101: two frames, position CRC 30
// - two-frame: additional-data CRC error in bit 29
// - two-frame: error bits in 27 and 26
// - two-frame: warning 23, reference mark 22, busy 21
// - two-frame: echoed range select code in 20:16
// - two-frame: additional data value in 15:0
// - motor encoder 00D8: error code in 23:8
// - motor encoder other codes: status summary 23:8
// - motor encoder: multi-turn upper seven bits 6:0
// - result word read-only, writes ignored
// - data ready shows 1 done, 0 in progress
`ifndef SERB_CONSTS_SVH
`define SERB_CONSTS_SVH

// apb map
`define SERB_ADDR_W 4
`define SERB_OFS_CTRL 4'h0
`define SERB_OFS_RESULT_B 4'h4

// control word fields
`define SERB_CTRL_CMD_HI 31
`define SERB_CTRL_CMD_LO 16
`define SERB_CTRL_READY_BIT 10
`define SERB_CTRL_PROTO_HI 1
`define SERB_CTRL_PROTO_LO 0
`define SERB_CTRL_RESET 32'h0000_0000
`define SERB_RESULT_RESET 32'h0000_0000

// result word fields
`define SERB_B_TIMEOUT 31
`define SERB_B_CRC_P 30
`define SERB_B_ERR_SINGLE 29
`define SERB_B_CRC_ADD 29
`define SERB_B_ERR1 27
`define SERB_B_ERR2 26
`define SERB_B_WARN 23
`define SERB_B_REFM 22
`define SERB_B_BUSY 21
`define SERB_B_MRS_HI 20
`define SERB_B_MRS_LO 16
`define SERB_B_ADD_HI 15
`define SERB_B_POS8_HI 7
`define SERB_B_MTE_HI 23
`define SERB_B_MTE_LO 8
`define SERB_B_MT7_HI 6

// command codes
`define SERB_CMD_POS_A 6'h07
`define SERB_CMD_POS_B 6'h2A
`define SERB_CMD_ADD_A 6'h38
`define SERB_CMD_ADD_B 6'h2D
`define SERB_MCMD_ERRCODE 16'h00D8

`endif

// file: verilog/serb_pkg.sv
// types shared by the serial encoder result word block
package serb_pkg;

    typedef enum logic [1:0] {
        SERB_PROTO_STATUS,
        SERB_PROTO_CMD,
        SERB_PROTO_MOTOR
    } serb_proto_t;

    // decoded content of one completed reception
    typedef struct packed {
        logic timeout;
        logic crc_pos;
        logic crc_add;
        logic err1;
        logic err2;
        logic encoder_warning_flag;
        logic reference_mark_flag;
        logic busy;
        logic [4:0] memory_range_select_code;
        logic [15:0] add_data;
        logic [7:0] pos_upper8;
        logic [15:0] mte_error_code;
        logic [15:0] mte_status;
        logic [6:0] multiturn_upper7;
    } serb_rx_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [3:0] paddr;
        logic [31:0] pwdata;
    } serb_apb_req_t;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } serb_apb_rsp_t;

endpackage : serb_pkg

// file: dv/serb_enc_model.sv
// encoder-side model: start pulse, programmable wait, done pulse with data
`timescale 1ns/10ps
`default_nettype none
module serb_enc_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // bench control
    input wire logic go,
    input wire logic [3:0] dly,
    input wire serb_pkg::serb_rx_t din,
    // receiver side
    output logic rx_start,
    output logic rx_done,
    output serb_pkg::serb_rx_t rx_data
);
    import serb_pkg::*;
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 4'h0;
            rx_start <= 1'b0;
            rx_done <= 1'b0;
            rx_data <= '0;
        end else begin
            cnt_q <= go ? dly : (cnt_q != 4'h0) ? cnt_q - 4'h1 : 4'h0;
            rx_start <= go;
            rx_done <= (cnt_q == 4'h1) && !go;
            // data only valid with done; toggles otherwise so stale values never match
            rx_data <= (cnt_q == 4'h1) ? din : ~rx_data;
        end
    end
endmodule : serb_enc_model
`default_nettype wire

// file: dv/tb_top.sv
// self-checking bench for the result word block
`timescale 1ns/10ps
`default_nettype none
`include "serb_consts.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import serb_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    serb_apb_req_t apb_req = '0;
    serb_apb_rsp_t apb_rsp;
    logic go = 1'b0;
    logic [3:0] dly = 4'h0;
    serb_rx_t din = '0;
    logic rx_start, rx_done;
    serb_rx_t rx_data;
    logic [15:0] cmd_code;
    serb_proto_t proto_sel;
    int failures = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'hC0D6;
    logic [32:0] expq[$];
    logic [32:0] e;
    serb_result_word dut (.sys_clk(sys_clk), .reset_n(reset_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .rx_start(rx_start), .rx_done(rx_done), .rx_data(rx_data),
        .cmd_code(cmd_code), .proto_sel(proto_sel));
    serb_enc_model enc (.sys_clk(sys_clk), .reset_n(reset_n), .go(go), .dly(dly), .din(din),
        .rx_start(rx_start), .rx_done(rx_done), .rx_data(rx_data));
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [31:0] exp_word(logic [1:0] p, logic [15:0] c, serb_rx_t r);
        logic [31:0] w;
        w = {r.timeout, 31'h0};
        if (p == SERB_PROTO_MOTOR) begin
            w[30:0] = {r.crc_pos, 6'h0, (c == 16'h00D8) ? r.mte_error_code : r.mte_status,
                1'b0, r.multiturn_upper7};
        end else if (p == SERB_PROTO_CMD && (c[5:0] == 6'h38 || c[5:0] == 6'h2D)) begin
            w[30:0] = {r.crc_pos, r.crc_add, 1'b0, r.err1, r.err2, 2'h0, r.encoder_warning_flag,
                r.reference_mark_flag, r.busy, r.memory_range_select_code,
                r.add_data};
        end else if (p == SERB_PROTO_CMD) begin
            w[30:0] = {r.crc_pos, r.err1, 21'h0, r.pos_upper8};
        end
        return w;
    endfunction : exp_word
    task automatic apb_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge sys_clk);
        apb_req.penable <= 1'b1;
        @(posedge sys_clk);
        while (apb_rsp.pready !== 1'b1) @(posedge sys_clk);
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        // idle cycle keeps each strobe to one assignment per time step
        @(posedge sys_clk);
    endtask : apb_xfer
    task automatic apb_rd(input logic [3:0] a, input logic [32:0] ex);
        expq.push_back(ex);
        apb_xfer(1'b0, a, 32'h0);
    endtask : apb_rd
    always @(posedge sys_clk) begin
        if (apb_req.psel && apb_req.penable && apb_rsp.pready === 1'b1 && !apb_req.pwrite) begin
            e = expq.pop_front();
            `CHK("pslverr", e[32], apb_rsp.pslverr)
            if (!e[32]) `CHK("prdata", e[31:0], apb_rsp.prdata)
        end
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial begin
        #(50 * 5000);
        failures++;
        end_of_test();
    end
    initial begin
        logic [17:0] tbl [9];
        logic [95:0] tmp;
        logic [31:0] prev, r;
        logic [15:0] cm;
        logic [1:0] pr;
        int n;
        tbl = '{{2'h1, 16'h0007}, {2'h1, 16'h002A}, {2'h1, 16'h0038}, {2'h1, 16'h002D},
            {2'h2, 16'h00D8}, {2'h2, 16'h0000}, {2'h2, 16'h0040}, {2'h2, 16'h0044},
            {2'h0, 16'h0000}};
        prev = 32'h0;
        repeat (6) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        apb_rd(4'h8, 33'h1_0000_0000);
        apb_xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
        for (int i = 0; i < 9; i++) begin
            pr = tbl[i][17:16];
            cm = tbl[i][15:0];
            // ready bit written opposite to its state, must not stick
            apb_xfer(1'b1, `SERB_OFS_CTRL, {cm, 14'h0, pr} | ((i == 0) ? 32'h400 : 32'h0));
            apb_rd(`SERB_OFS_CTRL, {1'b0, cm, 5'h0, (i > 0), 8'h0, pr});
            `CHK("cmd_code", cm, cmd_code)
            `CHK("proto_sel", pr, proto_sel)
            tmp = {xs(), xs(), xs()};
            r = xs();
            din <= tmp[75:0];
            dly <= 4'h7 + {1'b0, r[2:0]};
            go <= 1'b1;
            @(posedge sys_clk);
            go <= 1'b0;
            @(posedge sys_clk);
            apb_rd(`SERB_OFS_CTRL, {1'b0, cm, 5'h0, 1'b0, 8'h0, pr});
            apb_rd(`SERB_OFS_RESULT_B, {1'b0, prev});
            n = 0;
            do begin
                @(posedge sys_clk);
                n++;
            end while (rx_done !== 1'b1 && n < 30);
            `CHK("rx_done", 1'b1, rx_done)
            prev = exp_word(pr, cm, din);
            apb_rd(`SERB_OFS_RESULT_B, {1'b0, prev});
            apb_rd(`SERB_OFS_CTRL, {1'b0, cm, 5'h0, 1'b1, 8'h0, pr});
            apb_xfer(1'b1, `SERB_OFS_RESULT_B, xs());
            apb_rd(`SERB_OFS_RESULT_B, {1'b0, prev});
        end
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
